// [hdl/sfp_cfg.svh]
// Opcodes, status field positions, reset values and geometry of the serial flash front end
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

// Opcodes decoded by the front end
`define SFP_OP_STAT_WRITE  8'h01
`define SFP_OP_PROG        8'h02
`define SFP_OP_READ        8'h03
`define SFP_OP_WRDI        8'h04
`define SFP_OP_RDSR        8'h05
`define SFP_OP_WREN        8'h06
`define SFP_OP_FAST_READ   8'h0B
`define SFP_OP_SECT_ERASE  8'h20
`define SFP_OP_BLOCK_ERASE 8'h52
`define SFP_OP_AUTO_PROG   8'hAF

// Status register field positions
`define SFP_ST_BUSY        3'h0
`define SFP_ST_PERMIT      3'h1
`define SFP_ST_LVL0        3'h2
`define SFP_ST_LVL1        3'h3
`define SFP_ST_AUTO_INC    3'h6
`define SFP_ST_LOCK        3'h7

// Reset values
`define SFP_LVL_RESET      1'h1
`define SFP_PIN_IDLE       2'h3

// Shift counts
`define SFP_LAST_BIT       3'h7
`define SFP_LAST_ADDR      2'h2
`define SFP_ADDR_BYTES     2'h1

// Erase geometry: 4 KByte sectors inside 32 KByte blocks
`define SFP_SECTOR_MASK    24'hFF_F000
`define SFP_BLOCK_MASK     24'hFF_8000

// Received stream: marker bit above the byte flags an opcode
`define SFP_STREAM_W       9
`define SFP_FIFO_DEPTH     4

`endif

// [hdl/sfp_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps

module sfp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  // Filling and draining sides
  sfp_stream_if.snk   wr,
  sfp_stream_if.src   rd
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr_ptr;
    logic [AW:0]                 rd_ptr;
  } sfp_fifo_state_t;

  sfp_fifo_state_t s;
  sfp_fifo_state_t next_s;
  logic [AW:0]     fill;

  assign fill     = s.wr_ptr - s.rd_ptr;
  assign wr.ready = (fill != DEPTH_C);
  assign rd.valid = (fill != '0);
  assign rd.data  = s.mem[s.rd_ptr[AW-1:0]];

  always_comb begin
    next_s = s;
    if (wr.valid && wr.ready) begin
      next_s.mem[s.wr_ptr[AW-1:0]] = wr.data;
      next_s.wr_ptr = s.wr_ptr + 1'b1;
    end
    if (rd.valid && rd.ready) begin
      next_s.rd_ptr = s.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

// [hdl/sfp_pkg.sv]
// Types of the serial flash front end
package sfp_pkg;

  typedef enum logic [2:0] {
    PH_OPCODE = 3'b000,
    PH_ADDR   = 3'b001,
    PH_STWR   = 3'b010,
    PH_DATA   = 3'b011,
    PH_STATUS = 3'b100,
    PH_IGNORE = 3'b101
  } sfp_phase_t;

  typedef struct packed {
    logic [1:0]  sck_s;
    logic [1:0]  cs_s;
    logic [1:0]  si_s;
    logic [1:0]  hold_s;
    logic [1:0]  wp_s;
    logic        sck_prev;
    logic        paused;
    sfp_phase_t  phase;
    logic [2:0]  bit_cnt;
    logic [7:0]  shift_in;
    logic [7:0]  opcode;
    logic [1:0]  addr_cnt;
    logic [23:0] addr;
    logic [2:0]  out_cnt;
    logic        so;
    logic        so_oe;
    logic        busy;
    logic        permit;
    logic        lvl0;
    logic        lvl1;
    logic        auto_inc;
    logic        lock;
    logic        stwr_reject;
    logic        erase_req;
    logic        erase_block;
    logic [23:0] erase_addr;
    logic        push_valid;
    logic [8:0]  push_data;
    logic        overrun;
    logic        out_valid;
    logic [8:0]  out_data;
  } sfp_state_t;

endpackage

// [hdl/sfp_stream_if.sv]
// Valid/ready byte stream between the front end and its FIFO
`timescale 1ns/100ps
`include "sfp_cfg.svh"

interface sfp_stream_if;
  logic                      valid;
  logic                      ready;
  logic [`SFP_STREAM_W-1:0]  data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [hdl/sfp_top.sv]
// Serial flash device front end: SPI framing, pause, write guard and status register
`timescale 1ns/100ps
`include "sfp_cfg.svh"

module sfp_top (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // Serial pins from the host
  input  wire logic         sck_in,
  input  wire logic         cs_n_in,
  input  wire logic         si_in,
  input  wire logic         hold_n_in,
  input  wire logic         wp_n_in,
  // Serial data out, two signals of a tristate pin
  output logic              so_out,
  output logic              so_oe_out,
  // Array engine status
  input  wire logic         busy_in,
  input  wire logic         auto_inc_in,
  input  wire logic         permit_clear_in,
  // Received byte stream
  output logic [8:0]        data_out,
  output logic              data_valid_out,
  input  wire logic         data_ready_in,
  output logic              overrun_out,
  // Status register and command results
  output logic [7:0]        status_out,
  output logic              status_write_rejected_out,
  output logic              erase_req_out,
  output logic              erase_block_out,
  output logic [23:0]       erase_addr_out
);

  sfp_pkg::sfp_state_t s;
  sfp_pkg::sfp_state_t next_s;

  sfp_stream_if push_if ();
  sfp_stream_if pop_if ();

  logic       sck;
  logic       selected;
  logic       hold_low;
  logic       guard_low;
  logic       rise;
  logic       fall;
  logic [7:0] byte_in;
  logic [7:0] status_val;
  logic       last_bit;

  // Only the second flop of each synchroniser is looked at
  assign sck       = s.sck_s[1];
  assign selected  = !s.cs_s[1];
  assign hold_low  = !s.hold_s[1];
  assign guard_low = !s.wp_s[1];

  // Edges found by level change, so the idle level of the clock is irrelevant
  assign rise     = sck && !s.sck_prev && !s.paused;
  assign fall     = !sck && s.sck_prev && !s.paused;
  assign byte_in  = {s.shift_in[6:0], s.si_s[1]};
  assign last_bit = (s.bit_cnt == `SFP_LAST_BIT);

  always_comb begin
    status_val = '0;
    status_val[`SFP_ST_BUSY]     = s.busy;
    status_val[`SFP_ST_PERMIT]   = s.permit;
    status_val[`SFP_ST_LVL0]     = s.lvl0;
    status_val[`SFP_ST_LVL1]     = s.lvl1;
    status_val[`SFP_ST_AUTO_INC] = s.auto_inc;
    status_val[`SFP_ST_LOCK]     = s.lock;
  end

  // FIFO hookup
  assign push_if.valid = s.push_valid;
  assign push_if.data  = s.push_data;
  assign pop_if.ready  = !s.out_valid || data_ready_in;

  sfp_fifo #(
    .WIDTH (`SFP_STREAM_W),
    .DEPTH (`SFP_FIFO_DEPTH)
  ) u_fifo (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .wr       (push_if.snk),
    .rd       (pop_if.src)
  );

  always_comb begin
    next_s = s;

    // Pin synchronisers
    next_s.sck_s    = {s.sck_s[0], sck_in};
    next_s.cs_s     = {s.cs_s[0], cs_n_in};
    next_s.si_s     = {s.si_s[0], si_in};
    next_s.hold_s   = {s.hold_s[0], hold_n_in};
    next_s.wp_s     = {s.wp_s[0], wp_n_in};
    next_s.sck_prev = s.sck_s[1];

    // One-cycle pulses
    next_s.stwr_reject = 1'b0;
    next_s.erase_req   = 1'b0;

    // Engine busy and mode flags are copied, never written over the serial link; the engine can only clear permit
    next_s.busy     = busy_in;
    next_s.auto_inc = auto_inc_in;
    if (permit_clear_in) begin
      next_s.permit = 1'b0;
    end

    // Push handshake; room was checked when the byte was offered
    if (s.push_valid && push_if.ready) begin
      next_s.push_valid = 1'b0;
    end

    if (!selected) begin
      // Deselect clears any pause and any partial instruction
      next_s.paused   = 1'b0;
      next_s.phase    = sfp_pkg::PH_OPCODE;
      next_s.bit_cnt  = '0;
      next_s.addr_cnt = '0;
      next_s.out_cnt  = '0;
      next_s.so_oe    = 1'b0;
    end else if (!s.paused && hold_low && !sck) begin
      // Pause taken only with clock low; a change during clock high waits
      next_s.paused = 1'b1;
      next_s.so_oe  = 1'b0;
    end else if (s.paused) begin
      if (!hold_low && !sck) begin
        // Counters untouched, so the sequence picks up at the same bit
        next_s.paused = 1'b0;
      end
    end else if (rise) begin
      next_s.shift_in = byte_in;
      next_s.bit_cnt  = s.bit_cnt + 1'b1;
      if (last_bit) begin
        unique case (s.phase)
          sfp_pkg::PH_OPCODE: begin
            next_s.opcode = byte_in;
            if (push_if.ready) begin
              next_s.push_valid = 1'b1;
              next_s.push_data  = {1'b1, byte_in};
            end else begin
              next_s.overrun = 1'b1;
            end
            unique case (byte_in)
              `SFP_OP_RDSR: begin
                next_s.phase   = sfp_pkg::PH_STATUS;
                next_s.out_cnt = '0;
              end
              `SFP_OP_WREN: begin
                next_s.permit = 1'b1;
                next_s.phase  = sfp_pkg::PH_IGNORE;
              end
              `SFP_OP_WRDI: begin
                next_s.permit = 1'b0;
                next_s.phase  = sfp_pkg::PH_IGNORE;
              end
              `SFP_OP_STAT_WRITE: begin
                next_s.phase = sfp_pkg::PH_STWR;
              end
              `SFP_OP_SECT_ERASE, `SFP_OP_BLOCK_ERASE, `SFP_OP_READ,
              `SFP_OP_FAST_READ, `SFP_OP_PROG, `SFP_OP_AUTO_PROG: begin
                next_s.phase    = sfp_pkg::PH_ADDR;
                next_s.addr_cnt = '0;
              end
              default: begin
                next_s.phase = sfp_pkg::PH_DATA;
              end
            endcase
          end
          sfp_pkg::PH_ADDR: begin
            next_s.addr     = {s.addr[15:0], byte_in};
            next_s.addr_cnt = s.addr_cnt + `SFP_ADDR_BYTES;
            if (push_if.ready) begin
              next_s.push_valid = 1'b1;
              next_s.push_data  = {1'b0, byte_in};
            end else begin
              next_s.overrun = 1'b1;
            end
            if (s.addr_cnt == `SFP_LAST_ADDR) begin
              next_s.phase = sfp_pkg::PH_DATA;
              if (s.permit && (s.opcode == `SFP_OP_SECT_ERASE)) begin
                next_s.erase_req   = 1'b1;
                next_s.erase_block = 1'b0;
                next_s.erase_addr  = {s.addr[15:0], byte_in} & `SFP_SECTOR_MASK;
              end else if (s.permit && (s.opcode == `SFP_OP_BLOCK_ERASE)) begin
                next_s.erase_req   = 1'b1;
                next_s.erase_block = 1'b1;
                next_s.erase_addr  = {s.addr[15:0], byte_in} & `SFP_BLOCK_MASK;
              end
            end
          end
          sfp_pkg::PH_STWR: begin
            next_s.phase = sfp_pkg::PH_IGNORE;
            if (guard_low && s.lock) begin
              // Lock held by the guard pin freezes levels and lock alike
              next_s.stwr_reject = 1'b1;
            end else begin
              next_s.lvl0 = byte_in[`SFP_ST_LVL0];
              next_s.lvl1 = byte_in[`SFP_ST_LVL1];
              next_s.lock = byte_in[`SFP_ST_LOCK];
            end
          end
          sfp_pkg::PH_DATA: begin
            if (push_if.ready) begin
              next_s.push_valid = 1'b1;
              next_s.push_data  = {1'b0, byte_in};
            end else begin
              next_s.overrun = 1'b1;
            end
          end
          sfp_pkg::PH_STATUS, sfp_pkg::PH_IGNORE: begin
            next_s.phase = s.phase;
          end
          default: begin
            next_s.phase = sfp_pkg::PH_IGNORE;
          end
        endcase
      end
    end else if (fall && (s.phase == sfp_pkg::PH_STATUS)) begin
      // Status repeats while the host keeps clocking, read live each bit
      next_s.so      = status_val[~s.out_cnt];
      next_s.so_oe   = 1'b1;
      next_s.out_cnt = s.out_cnt + 1'b1;
    end

    // Output register stage of the stream
    if (pop_if.valid && pop_if.ready) begin
      next_s.out_valid = 1'b1;
      next_s.out_data  = pop_if.data;
    end else if (data_ready_in) begin
      next_s.out_valid = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s        <= '0;
      s.cs_s   <= `SFP_PIN_IDLE;
      s.hold_s <= `SFP_PIN_IDLE;
      s.wp_s   <= `SFP_PIN_IDLE;
      s.lvl0   <= `SFP_LVL_RESET;
      s.lvl1   <= `SFP_LVL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign so_out                    = s.so;
  assign so_oe_out                 = s.so_oe;
  assign data_out                  = s.out_data;
  assign data_valid_out            = s.out_valid;
  assign overrun_out               = s.overrun;
  assign status_write_rejected_out = s.stwr_reject;
  assign erase_req_out             = s.erase_req;
  assign erase_block_out           = s.erase_block;
  assign erase_addr_out            = s.erase_addr;
  assign status_out = {s.lock, s.auto_inc, 2'h0, s.lvl1, s.lvl0, s.permit, s.busy};

endmodule

// [verification/sfp_host.sv]
// Host model driving the serial pins of the flash front end
`timescale 1ns/100ps
module sfp_host (
  // Clock
  input  wire logic clk_in,
  // Serial pins
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      si_out,
  output logic      hold_n_out,
  output logic      wp_n_out,
  input  wire logic so_in
);
  logic mode3;

  initial begin
    mode3 = 1'b0;
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
    hold_n_out = 1'b1;
    wp_n_out = 1'b1;
  end

  // Half of a 160 ns sck period, moved just after a clock edge
  task automatic half();
    repeat (16) @(posedge clk_in);
    #1;
  endtask

  // Clock rests at the mode's level between frames
  task automatic start(input logic m3);
    mode3 = m3;
    sck_out = m3;
    half();
    cs_n_out = 1'b0;
    half();
  endtask

  task automatic xfer(input logic [7:0] b, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sck_out = 1'b0;
      si_out = b[i];
      half();
      sck_out = 1'b1;
      r[i] = so_in;
      half();
    end
  endtask

  task automatic stop();
    sck_out = mode3;
    half();
    cs_n_out = 1'b1;
    si_out = ~si_out; // Released line must not keep the last bit
    half();
  endtask

  task automatic set_pin(input logic h, input logic w);
    hold_n_out = h;
    wp_n_out = w;
    half();
  endtask

  // Clock and data wiggle while paused, to be ignored
  task automatic tick();
    sck_out = ~sck_out;
    si_out = 1'($urandom_range(1));
    half();
  endtask
endmodule

// [verification/sfp_props.sv]
// Assertions on the pins and status outputs of the serial flash front end
`timescale 1ns/100ps
module sfp_props (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  // Serial pins
  input wire logic        sck_in,
  input wire logic        cs_n_in,
  input wire logic        hold_n_in,
  input wire logic        wp_n_in,
  input wire logic        so_out,
  input wire logic        so_oe_out,
  // Engine inputs and results
  input wire logic        busy_in,
  input wire logic        auto_inc_in,
  input wire logic [7:0]  status_out,
  input wire logic        status_write_rejected_out,
  input wire logic        erase_req_out,
  input wire logic        erase_block_out,
  input wire logic [23:0] erase_addr_out
);
  // Guard pin low time; the decode sees the pin only after its synchroniser
  logic [3:0] wp_low_cnt;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      wp_low_cnt <= 4'h0;
    else if (wp_n_in)
      wp_low_cnt <= 4'h0;
    else if (wp_low_cnt != 4'hF)
      wp_low_cnt <= wp_low_cnt + 4'h1;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_oe_idle; cs_n_in [*7] |-> !so_oe_out; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("so driven deselected");
  property p_reserved; status_out[5:4] == 2'b00; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");
  property p_copy; {status_out[6], status_out[0]} == $past({auto_inc_in, busy_in}); endproperty
  a_copy: assert property (p_copy) else $error("busy or mode flag wrong");
  property p_lock; wp_low_cnt >= 4'h6 && $past(status_out[7]) |->
    status_out[7] && $stable(status_out[3:2]); endproperty
  a_lock: assert property (p_lock) else $error("locked levels changed");
  property p_reject; status_write_rejected_out |->
    status_out[7] && wp_low_cnt >= 4'h3 ##1 !status_write_rejected_out; endproperty
  a_reject: assert property (p_reject) else $error("bad status write refusal");
  property p_erase; erase_req_out |-> (erase_block_out ? erase_addr_out[14:0] == 15'h0000
    : erase_addr_out[11:0] == 12'h000); endproperty
  a_erase: assert property (p_erase) else $error("erase address not aligned");
  property p_pause; (!cs_n_in && !hold_n_in && !sck_in) [*6] |-> !so_oe_out; endproperty
  a_pause: assert property (p_pause) else $error("so driven while paused");
  property p_so_edge; so_oe_out && $past(so_oe_out) && $changed(so_out) |->
    $past(!sck_in, 3); endproperty
  a_so_edge: assert property (p_so_edge) else $error("so moved off a falling edge");
  property p_oe_rise; $rose(so_oe_out) |-> !cs_n_in && $past(!sck_in, 3); endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("so enabled without cause");

  c_erase: cover property (erase_req_out && erase_block_out);
  c_reject: cover property (status_write_rejected_out);
  c_read: cover property ($rose(so_oe_out));
endmodule

bind sfp_top sfp_props u_props (.*);

// [verification/tb.sv]
// Self-checking bench of the serial flash front end against a host model
`timescale 1ns/100ps
module tb;
  logic        clk_in, rst_n_in, busy, auto_inc, permit_clr, dready, stall;
  logic        sck, cs_n, si, hold_n, wp_n, so, so_oe, dvalid, overrun;
  logic        rej, ereq, eblk, lock, l1, l0, perm, e_blk;
  logic [7:0]  status, r, v;
  logic [8:0]  dout;
  logic [23:0] eaddr, e_addr, a;
  logic [31:0] pay;
  logic [8:0]  got[$], exp_q[$];
  int          fails, total_checks, rej_cnt, e_cnt, rejs, n_erase;
  wire         so_pin = so_oe ? so : 1'bz;

  sfp_host host (.clk_in(clk_in), .sck_out(sck), .cs_n_out(cs_n), .si_out(si),
    .hold_n_out(hold_n), .wp_n_out(wp_n), .so_in(so_pin));
  sfp_top uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .sck_in(sck), .cs_n_in(cs_n),
    .si_in(si), .hold_n_in(hold_n), .wp_n_in(wp_n), .so_out(so), .so_oe_out(so_oe),
    .busy_in(busy), .auto_inc_in(auto_inc), .permit_clear_in(permit_clr),
    .data_out(dout), .data_valid_out(dvalid), .data_ready_in(dready),
    .overrun_out(overrun), .status_out(status), .status_write_rejected_out(rej),
    .erase_req_out(ereq), .erase_block_out(eblk), .erase_addr_out(eaddr));

  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) dready <= #1 !stall && 1'($urandom_range(1));

  always @(posedge clk_in) begin
    if (rej === 1'b1) rej_cnt++;
    if (ereq === 1'b1) begin
      e_cnt++;
      e_addr = eaddr;
      e_blk = eblk;
    end
    if (dvalid === 1'b1 && dready === 1'b1) got.push_back(dout);
  end

  function automatic logic [7:0] st_exp();
    return {lock, auto_inc, 2'b00, l1, l0, perm, busy};
  endfunction

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic step();
    @(posedge clk_in);
    #1;
  endtask

  task automatic do_reset();
    rst_n_in = 1'b0;
    repeat (5) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    {lock, l1, l0, perm} = 4'h6;
    repeat (4) step();
    chk("status after reset", st_exp(), status);
    chk("overrun after reset", 1'b0, overrun);
    chk("so enable idle", 1'b0, so_oe);
  endtask

  task automatic send(input logic [7:0] op, input int nb, input logic [31:0] p);
    host.start(1'($urandom_range(1)));
    host.xfer(op, 8, r);
    for (int k = nb - 1; k >= 0; k--)
      host.xfer(p[8*k +: 8], 8, r);
    host.stop();
  endtask

  task automatic rdsr();
    send(8'h05, 1, 32'h0);
    chk("status read", st_exp(), r);
    chk("status port", st_exp(), status);
  endtask

  task automatic drain();
    for (int w = 0; w < 400 && got.size() < exp_q.size(); w++) step();
    chk("stream words", exp_q.size(), got.size());
    foreach (exp_q[k]) chk("stream word", exp_q[k], got[k]);
    got.delete();
    exp_q.delete();
  endtask

  initial begin
    #450_000;
    fails++;
    $display("[ERR] run time expected short seen limit");
    results();
  end

  initial begin
    clk_in = 1'b0;
    busy = 1'b0;
    auto_inc = 1'b0;
    permit_clr = 1'b0;
    dready = 1'b0;
    stall = 1'b0;
    rst_n_in = 1'b0;
    pay = $urandom(18368);
    do_reset();
    for (int k = 0; k < 4; k++) begin
      {auto_inc, busy} = 2'(k);
      rdsr();
    end
    {auto_inc, busy} = 2'b00;
    send(8'h06, 0, 32'h0);
    perm = 1'b1;
    rdsr();
    // Clear command cut one bit short must leave the latch set
    host.start(1'b1);
    host.xfer(8'h04, 7, r);
    host.stop();
    rdsr();
    permit_clr = 1'b1;
    step();
    permit_clr = 1'b0;
    perm = 1'b0;
    rdsr();
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      if (i < 4) v[7] = ~i[1];
      host.set_pin(1'b1, ~i[0]);
      send(8'h01, 1, {24'h00_0000, v});
      if (i[0] && lock) rejs++;
      else {lock, l1, l0} = {v[7], v[3], v[2]};
      rdsr();
    end
    chk("refused writes", rejs, rej_cnt);
    host.set_pin(1'b1, 1'b1);
    for (int j = 0; j < 3; j++) begin
      a = 24'($urandom);
      send((j < 2) ? 8'h06 : 8'h04, 0, 32'h0);
      send(j[0] ? 8'h52 : 8'h20, 3, {8'h00, a});
      n_erase += (j < 2);
      chk("erase count", n_erase, e_cnt);
      if (j < 2) begin
        chk("erase kind", j[0], e_blk);
        chk("erase address", a & ~(j[0] ? 24'h00_7FFF : 24'h00_0FFF), e_addr);
      end
    end
    send(8'h04, 0, 32'h0);
    // Pause asked with sck high, taken at the next low phase
    host.start(1'b0);
    host.xfer(8'h06, 4, r);
    host.set_pin(1'b0, 1'b1);
    host.tick();
    host.tick();
    host.tick();
    chk("so enable paused", 1'b0, so_oe);
    host.set_pin(1'b1, 1'b1);
    host.xfer(8'h60, 4, r);
    host.stop();
    perm = 1'b1;
    rdsr();
    host.start(1'b0);
    host.xfer(8'h04, 4, r);
    host.set_pin(1'b0, 1'b1);
    host.tick();
    host.stop();
    host.set_pin(1'b1, 1'b1);
    rdsr();
    repeat (50) step();
    got.delete();
    for (int f = 0; f < 4; f++) begin
      pay = $urandom;
      if (f == 2) stall = 1'b1;
      v = (f == 1) ? 8'h02 : 8'hC3;
      send(v, (f == 3) ? 1 : 3, pay);
      exp_q.push_back({1'b1, v});
      for (int k = 2; k >= 0 && f < 3; k--) exp_q.push_back({1'b0, pay[8*k +: 8]});
      if (f == 1) drain();
    end
    chk("overrun when full", 1'b1, overrun);
    stall = 1'b0;
    drain();
    do_reset();
    results();
  end
endmodule
